// *** verilog/fdhp_consts.svh ***
`ifndef FDHP_CONSTS_SVH
`define FDHP_CONSTS_SVH

// ----------------------------------------------------------------
// bus geometry
// ----------------------------------------------------------------
`define FDHP_AW            6
`define FDHP_DW            8
`define FDHP_DEPTH         64

// ----------------------------------------------------------------
// port-local register locations
// ----------------------------------------------------------------
`define FDHP_ADDR_CTRL     6'h3d
`define FDHP_ADDR_STATUS   6'h3e
`define FDHP_ADDR_AUXSEL   6'h3f

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define FDHP_CTRL_RUN_BIT  0
`define FDHP_STAT_PEND_BIT 0
`define FDHP_STAT_PD_BIT   1
`define FDHP_SEL_W         3
`define FDHP_SEL_RST       3'h0
`define FDHP_MEM_RST       8'h00
`define FDHP_DATA_RST      8'h00

// ----------------------------------------------------------------
// clocking figures
// ----------------------------------------------------------------
`define FDHP_SYS_HZ        25000000
`define FDHP_XTAL_HZ       8192000
`define FDHP_AUX_MIN_HZ    64000
`define FDHP_AUX_MAX_DIV   (`FDHP_XTAL_HZ / `FDHP_AUX_MIN_HZ)
`define FDHP_DIV_W         7

`endif

// *** verilog/fdhp_pkg.sv ***
package fdhp_pkg;

  typedef enum logic [2:0] {
    FDHP_ST_IDLE = 3'b001,
    FDHP_ST_WR   = 3'b010,
    FDHP_ST_RD   = 3'b100
  } fdhp_state_t;

  typedef logic [5:0] fdhp_addr_t;
  typedef logic [7:0] fdhp_data_t;

endpackage

// *** verilog/fdhp_mem_if.sv ***
`timescale 1ns/1ps

interface fdhp_mem_if;
  logic                 clr;
  logic                 we;
  fdhp_pkg::fdhp_addr_t waddr;
  fdhp_pkg::fdhp_data_t wdata;
  fdhp_pkg::fdhp_addr_t raddr;
  fdhp_pkg::fdhp_data_t rdata;

  modport ctrl (output clr, output we, output waddr, output wdata, output raddr, input rdata);
  modport mem  (input clr, input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// *** verilog/fdhp_regmem.sv ***
`timescale 1ns/1ps
`include "fdhp_consts.svh"

module fdhp_regmem (
  input wire logic  clk,   // system clock
  input wire logic  rst,   // async reset, active high
  fdhp_mem_if.mem   mbus   // access from the port
);

  fdhp_pkg::fdhp_data_t mem_q [`FDHP_DEPTH];

  // ----------------------------------------------------------------
  // storage, wiped by the clear input
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < `FDHP_DEPTH; i++) begin
        mem_q[i] <= `FDHP_MEM_RST;
      end
    end else if (mbus.clr) begin
      for (int i = 0; i < `FDHP_DEPTH; i++) begin
        mem_q[i] <= `FDHP_MEM_RST;
      end
    end else if (mbus.we) begin
      mem_q[mbus.waddr] <= mbus.wdata;
    end
  end

  // ----------------------------------------------------------------
  // registered read port
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mbus.rdata <= `FDHP_MEM_RST;
    end else begin
      mbus.rdata <= mem_q[mbus.raddr];
    end
  end

endmodule

// *** verilog/fdhp_host_port.sv ***
`timescale 1ns/1ps
`include "fdhp_consts.svh"

// Contract
// R1: strobes and data bus are honoured only while chip select is low.
// R2: host puts the target register location on the six address inputs.
// R3: eight-bit data bus; host drives on writes, device drives on reads.
// R4: store strobe with chip select writes bus data to the addressed register.
// R5: load strobe with chip select places addressed register on the bus.
// R6: alert output low while an interrupt is pending, high otherwise.
// R7: clear low resets every register to default and enters power-down.
// R8: aux clock driven only while its gate is low; gate pulled high; here AUX_CLOCK_GATE_N has no pull-up and must be driven.
// R9: aux clock selectable from 64 kHz to 8.192 MHz, from the crystal.
// R10: all timing derives from the 8.192 MHz crystal master clock; here only the aux clock does, all else runs on the 25 MHz CLK_SYS.
// R11: strobes active low; write taken at store release; read valid while low.
module fdhp_host_port (
  input  wire logic       CLK_SYS,           // 25 MHz system clock
  input  wire logic       RST,               // async reset, active high
  input  wire logic       CS_N,              // chip select
  input  wire logic       LOAD_N,            // load (read) strobe
  input  wire logic       STORE_N,           // store (write) strobe
  input  wire logic [5:0] REG_ADDR,          // register location
  input  wire logic [7:0] REG_DATA_I,        // data bus, pin level
  output logic      [7:0] REG_DATA_O,        // data bus, driven value
  output logic            REG_DATA_OE,       // data bus enable
  output logic            HOST_ALERT_N,      // interrupt to host
  input  wire logic       CLEAR_N,           // clear, active low
  input  wire logic       ALERT_EVENT,       // event pulse from the core
  output logic            POWER_DOWN,        // core power-down request
  input  wire logic       CRYSTAL_IN,        // crystal oscillator input
  output logic            CRYSTAL_DRIVE,     // crystal feedback drive
  input  wire logic       AUX_CLOCK_GATE_N,  // aux clock gate
  output logic            AUX_CLOCK_PIN,     // aux clock value
  output logic            AUX_CLOCK_OE       // aux clock enable
);

  fdhp_mem_if mbus ();

  fdhp_regmem u_mem (
    .clk  (CLK_SYS),
    .rst  (RST),
    .mbus (mbus.mem)
  );

  fdhp_pkg::fdhp_state_t  state_q;
  fdhp_pkg::fdhp_addr_t   wr_addr_q;
  fdhp_pkg::fdhp_data_t   wr_data_q;
  fdhp_pkg::fdhp_data_t   data_q;
  logic                   oe_q;
  logic                   run_q;
  logic                   pend_q;
  logic [`FDHP_SEL_W-1:0] sel_q;
  logic                   xtal_q;
  logic [`FDHP_DIV_W-1:0] div_q;
  logic                   aux_q;
  logic                   aux_oe_q;
  logic                   drive_q;
  logic                   clear;
  logic                   sel_cs;
  logic                   rd_act;
  logic                   wr_act;
  logic                   commit;
  logic                   rd_done;
  logic                   xtal_rise;

  function automatic logic is_local(input fdhp_pkg::fdhp_addr_t a);
    is_local = (a == `FDHP_ADDR_CTRL) || (a == `FDHP_ADDR_STATUS) || (a == `FDHP_ADDR_AUXSEL);
  endfunction

  // picks the divider tap for select k: crystal itself at 0, else 1/2^k
  function automatic logic aux_tap(input logic [`FDHP_SEL_W-1:0] k,
                                   input logic                   x,
                                   input logic [`FDHP_DIV_W-1:0] d);
    aux_tap = (k == `FDHP_SEL_RST) ? x : d[k - 3'h1];
  endfunction

  // ----------------------------------------------------------------
  // strobe qualification
  // ----------------------------------------------------------------
  assign clear  = !CLEAR_N;
  assign sel_cs = !CS_N && !clear;                              // R1
  assign wr_act = sel_cs && !STORE_N;                           // R11
  assign rd_act = sel_cs && !LOAD_N;                            // R11

  // write commits on the store release while still selected
  assign commit  = (state_q == fdhp_pkg::FDHP_ST_WR) && sel_cs && STORE_N;   // R4 R11
  assign rd_done = (state_q == fdhp_pkg::FDHP_ST_RD) && sel_cs && LOAD_N;

  // ----------------------------------------------------------------
  // access sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      state_q <= fdhp_pkg::FDHP_ST_IDLE;
    end else begin
      case (state_q)
        fdhp_pkg::FDHP_ST_IDLE: begin
          if (wr_act) begin
            state_q <= fdhp_pkg::FDHP_ST_WR;
          end else if (rd_act) begin
            state_q <= fdhp_pkg::FDHP_ST_RD;
          end
        end
        fdhp_pkg::FDHP_ST_WR: begin
          // deselect mid-strobe abandons the write
          if (!wr_act) begin
            state_q <= fdhp_pkg::FDHP_ST_IDLE;                  // R1
          end
        end
        fdhp_pkg::FDHP_ST_RD: begin
          if (!rd_act) begin
            state_q <= fdhp_pkg::FDHP_ST_IDLE;
          end
        end
        default: begin
          state_q <= fdhp_pkg::FDHP_ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // write capture: last address and data seen while the strobe is low
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      wr_addr_q <= 6'h00;
      wr_data_q <= `FDHP_DATA_RST;
    end else if (wr_act) begin
      wr_addr_q <= REG_ADDR;                                    // R2
      wr_data_q <= REG_DATA_I;                                  // R3
    end
  end

  assign mbus.clr   = clear;                                    // R7
  assign mbus.we    = commit && !is_local(wr_addr_q);           // R4
  assign mbus.waddr = wr_addr_q;
  assign mbus.wdata = wr_data_q;
  assign mbus.raddr = REG_ADDR;

  // ----------------------------------------------------------------
  // local control: run bit and aux clock select
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      run_q <= 1'b0;
      sel_q <= `FDHP_SEL_RST;
    end else if (clear) begin
      run_q <= 1'b0;                                            // R7
      sel_q <= `FDHP_SEL_RST;                                   // R7
    end else if (commit && wr_addr_q == `FDHP_ADDR_CTRL) begin
      run_q <= wr_data_q[`FDHP_CTRL_RUN_BIT];                   // R4
    end else if (commit && wr_addr_q == `FDHP_ADDR_AUXSEL) begin
      sel_q <= wr_data_q[`FDHP_SEL_W-1:0];                      // R9
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      POWER_DOWN <= 1'b1;
    end else begin
      POWER_DOWN <= !run_q || clear;                            // R7
    end
  end

  // ----------------------------------------------------------------
  // interrupt: cleared when a status read ends; a new event wins
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      pend_q <= 1'b0;
    end else if (clear) begin
      pend_q <= 1'b0;                                           // R7
    end else if (ALERT_EVENT && run_q) begin
      pend_q <= 1'b1;
    end else if (rd_done && REG_ADDR == `FDHP_ADDR_STATUS) begin
      pend_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      HOST_ALERT_N <= 1'b1;
    end else begin
      HOST_ALERT_N <= !pend_q;                                  // R6
    end
  end

  // ----------------------------------------------------------------
  // read path: mux on the registered memory word, then a bus register
  // ----------------------------------------------------------------
  logic [5:0] rd_addr_q;

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      rd_addr_q <= 6'h00;
    end else begin
      rd_addr_q <= REG_ADDR;
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      data_q <= `FDHP_DATA_RST;
    end else begin
      case (rd_addr_q)
        `FDHP_ADDR_CTRL:   data_q <= {7'h00, run_q};
        `FDHP_ADDR_STATUS: data_q <= {6'h00, POWER_DOWN, pend_q};
        `FDHP_ADDR_AUXSEL: data_q <= {5'h00, sel_q};
        default:           data_q <= mbus.rdata;                // R5
      endcase
    end
  end

  // enable rises on the same edge as the new data word, so the pins never show a stale word
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      oe_q <= 1'b0;
    end else begin
      oe_q <= rd_act && (state_q == fdhp_pkg::FDHP_ST_RD);      // R5 R11
    end
  end

  assign REG_DATA_O  = data_q;                                  // R3
  assign REG_DATA_OE = oe_q;                                    // R3

  // ----------------------------------------------------------------
  // crystal sampling and feedback drive
  // ----------------------------------------------------------------
  // sampling at 25 MHz stays above twice the crystal rate
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      xtal_q  <= 1'b0;
      drive_q <= 1'b1;
    end else begin
      xtal_q  <= CRYSTAL_IN;                                    // R10
      drive_q <= !CRYSTAL_IN || clear;
    end
  end

  assign CRYSTAL_DRIVE = drive_q;
  assign xtal_rise     = CRYSTAL_IN && !xtal_q;

  // ----------------------------------------------------------------
  // aux clock divider, counted on crystal edges only
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      div_q <= 7'h00;
    end else if (POWER_DOWN) begin
      div_q <= 7'h00;
    end else if (xtal_rise) begin
      div_q <= div_q + 7'h01;                                   // R10
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      aux_q    <= 1'b0;
      aux_oe_q <= 1'b0;
    end else begin
      aux_oe_q <= !AUX_CLOCK_GATE_N;                            // R8
      aux_q    <= !AUX_CLOCK_GATE_N && !POWER_DOWN
                  && aux_tap(sel_q, xtal_q, div_q);             // R8 R9
    end
  end

  assign AUX_CLOCK_PIN = aux_q;
  assign AUX_CLOCK_OE  = aux_oe_q;

endmodule

// *** sim/fdhp_host_port_properties.sv ***
`timescale 1ns/1ps

module fdhp_host_port_properties (
  input wire logic       CLK_SYS,          // system clock
  input wire logic       RST,              // async reset
  input wire logic       CS_N,             // chip select
  input wire logic       LOAD_N,           // read strobe
  input wire logic       STORE_N,          // write strobe
  input wire logic [5:0] REG_ADDR,         // register location
  input wire logic       REG_DATA_OE,      // bus enable
  input wire logic       HOST_ALERT_N,     // interrupt out
  input wire logic       CLEAR_N,          // clear
  input wire logic       ALERT_EVENT,      // core event
  input wire logic       POWER_DOWN,       // power-down
  input wire logic       AUX_CLOCK_GATE_N, // aux gate
  input wire logic       AUX_CLOCK_PIN,    // aux value
  input wire logic       AUX_CLOCK_OE      // aux enable
);
  // ------------------------------------------------------------
  // bus, alert and aux clock relations
  // ------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (RST);

  oe_rise_a: assert property ((!CS_N && !LOAD_N && STORE_N && CLEAR_N) [*3] |=> REG_DATA_OE)
    else $error("read enable late");
  oe_drop_a: assert property ((CS_N || LOAD_N) |=> !REG_DATA_OE)
    else $error("bus driven without selected read");
  oe_store_a: assert property ((!STORE_N && !CS_N) |=> !REG_DATA_OE)
    else $error("bus driven during write");
  alert_fall_a: assert property ($fell(HOST_ALERT_N) |-> $past(ALERT_EVENT, 2))
    else $error("alert without event");
  alert_set_a: assert property (
    (ALERT_EVENT && !POWER_DOWN && CLEAR_N && $past(CLEAR_N)) |-> ##2 !HOST_ALERT_N)
    else $error("alert missing");
  rd_clear_a: assert property (
    ($rose(LOAD_N) && !CS_N && REG_ADDR == 6'h3e && !ALERT_EVENT) |-> ##2 HOST_ALERT_N)
    else $error("alert not cleared by status read");
  clr_pd_a: assert property (!CLEAR_N |-> ##2 POWER_DOWN)
    else $error("clear did not power down");
  clr_alert_a: assert property ((!CLEAR_N && !ALERT_EVENT) |-> ##2 HOST_ALERT_N)
    else $error("clear left alert");
  aux_on_a: assert property (!AUX_CLOCK_GATE_N |=> AUX_CLOCK_OE)
    else $error("aux clock not enabled");
  aux_off_a: assert property (AUX_CLOCK_GATE_N [*2] |-> !AUX_CLOCK_OE && !AUX_CLOCK_PIN)
    else $error("aux clock not gated");

  cover property (REG_DATA_OE);
  cover property ($fell(HOST_ALERT_N));
  cover property (AUX_CLOCK_OE && $rose(AUX_CLOCK_PIN));
endmodule

bind fdhp_host_port fdhp_host_port_properties u_props (
  .CLK_SYS(CLK_SYS), .RST(RST), .CS_N(CS_N), .LOAD_N(LOAD_N), .STORE_N(STORE_N),
  .REG_ADDR(REG_ADDR), .REG_DATA_OE(REG_DATA_OE), .HOST_ALERT_N(HOST_ALERT_N),
  .CLEAR_N(CLEAR_N), .ALERT_EVENT(ALERT_EVENT), .POWER_DOWN(POWER_DOWN),
  .AUX_CLOCK_GATE_N(AUX_CLOCK_GATE_N), .AUX_CLOCK_PIN(AUX_CLOCK_PIN),
  .AUX_CLOCK_OE(AUX_CLOCK_OE));

// *** sim/fdhp_mcu_model.sv ***
`timescale 1ns/1ps

module fdhp_mcu_model (
  input  wire logic       clk,     // system clock
  input  wire logic       dev_oe,  // device drives bus
  input  wire logic [7:0] dev_d,   // device bus value
  output logic            cs_n,    // chip select
  output logic            load_n,  // read strobe
  output logic            store_n, // write strobe
  output logic      [5:0] addr,    // register location
  output logic      [7:0] bus      // resolved bus level
);
  logic       drv;
  logic [7:0] hd;
  logic [7:0] last;

  initial begin
    {cs_n, load_n, store_n, drv} = 4'he;
    {addr, hd, last} = '0;
  end

  // released bus flips every cycle so stale data cannot pass
  always_comb bus = dev_oe ? dev_d : (drv ? hd : ~last);
  always @(posedge clk) last <= bus;

  task automatic wr(input logic [5:0] a, input logic [7:0] d, input logic sel);
    @(posedge clk);
    cs_n    <= sel;
    store_n <= 1'b0;
    addr    <= a;
    hd      <= d;
    drv     <= 1'b1;
    @(posedge clk);
    store_n <= 1'b1;
    @(posedge clk);
    cs_n    <= 1'b1;
    drv     <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [5:0] a, input logic sel, output logic ok,
                    output logic [7:0] d);
    ok = 1'b0;
    d  = 8'h00;
    @(posedge clk);
    cs_n   <= sel;
    load_n <= 1'b0;
    addr   <= a;
    for (int i = 0; i < 6 && !ok; i++) begin
      @(posedge clk);
      ok = dev_oe;
      d  = bus;
    end
    load_n <= 1'b1;
    @(posedge clk);
    cs_n <= 1'b1;
    @(posedge clk);
  endtask
endmodule

// *** sim/fdhp_host_port_tb.sv ***
`timescale 1ns/1ps

module fdhp_host_port_tb;
  logic       clk, rst, clr_n, evt, xtal, gate_n, cs_n, ld_n, st_n, ok;
  logic       oe, alert_n, pd, apin, aoe, xd;
  logic [5:0] addr;
  logic [7:0] bus, d_o, d;
  int         n_errors, samples_checked, c, xbad;

  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  initial begin
    xtal = 0;
    forever #61.035 xtal = ~xtal;
  end

  fdhp_host_port dut (.CLK_SYS(clk), .RST(rst), .CS_N(cs_n), .LOAD_N(ld_n), .STORE_N(st_n),
    .REG_ADDR(addr), .REG_DATA_I(bus), .REG_DATA_O(d_o), .REG_DATA_OE(oe),
    .HOST_ALERT_N(alert_n), .CLEAR_N(clr_n), .ALERT_EVENT(evt), .POWER_DOWN(pd),
    .CRYSTAL_IN(xtal), .CRYSTAL_DRIVE(xd), .AUX_CLOCK_GATE_N(gate_n),
    .AUX_CLOCK_PIN(apin), .AUX_CLOCK_OE(aoe));
  fdhp_mcu_model mcu (.clk(clk), .dev_oe(oe), .dev_d(d_o), .cs_n(cs_n), .load_n(ld_n),
    .store_n(st_n), .addr(addr), .bus(bus));

  // ------------------------------------------------------------
  // checking and closing
  // ------------------------------------------------------------
  task automatic check(string what, logic [7:0] exp, logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic results();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic edges(int n);
    repeat (n) @(posedge clk);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_rw();
    mcu.wr(6'h00, 8'ha5, 1'b0);
    mcu.wr(6'h3c, 8'h5a, 1'b0);
    mcu.wr(6'h00, 8'hff, 1'b1);
    mcu.rd(6'h00, 1'b1, ok, d);
    check("unselected read", 8'h00, {7'h0, ok});
    mcu.rd(6'h00, 1'b0, ok, d);
    check("reg 00", 8'ha5, d);
    mcu.rd(6'h3c, 1'b0, ok, d);
    check("reg 3c", 8'h5a, d);
  endtask

  task automatic t_irq();
    mcu.wr(6'h3d, 8'h01, 1'b0);
    // power-down follows the run bit one cycle after the commit
    edges(1);
    check("run", 8'h00, {7'h0, pd});
    @(posedge clk);
    evt <= 1'b1;
    @(posedge clk);
    evt <= 1'b0;
    edges(2);
    check("alert set", 8'h00, {7'h0, alert_n});
    mcu.rd(6'h3e, 1'b0, ok, d);
    check("status", 8'h01, d);
    edges(3);
    check("alert cleared", 8'h01, {7'h0, alert_n});
  endtask

  task automatic aux_count(int n);
    logic p, xp;
    p = 1'b1;
    xp = xtal;
    c = 0;
    xbad = 0;
    repeat (n) begin
      @(posedge clk);
      if (apin && !p) c++;
      if (xd !== ~xp) xbad++;
      p = apin;
      xp = xtal;
    end
  endtask

  task automatic t_aux();
    @(posedge clk);
    gate_n <= 1'b0;
    aux_count(1000);
    check("aux enable", 8'h01, {7'h0, aoe});
    check("aux full rate", 8'h01, {7'h0, c >= 326 && c <= 329});
    check("crystal drive", 8'h01, {7'h0, xbad == 0});
    mcu.wr(6'h3f, 8'h07, 1'b0);
    aux_count(4000);
    check("aux slow rate", 8'h01, {7'h0, c >= 9 && c <= 11});
    gate_n <= 1'b1;
    edges(3);
    check("aux gated", 8'h00, {6'h0, aoe, apin});
  endtask

  task automatic t_clear();
    @(posedge clk);
    clr_n <= 1'b0;
    @(posedge clk);
    clr_n <= 1'b1;
    edges(3);
    check("clear pd", 8'h01, {7'h0, pd});
    mcu.rd(6'h00, 1'b0, ok, d);
    check("clear reg", 8'h00, d);
    mcu.rd(6'h3e, 1'b0, ok, d);
    check("clear status", 8'h02, d);
  endtask

  initial begin
    edges(12000);
    n_errors++;
    results();
  end

  initial begin
    rst = 1'b1;
    clr_n = 1'b1;
    evt = 1'b0;
    gate_n = 1'b1;
    n_errors = 0;
    samples_checked = 0;
    edges(2);
    rst <= 1'b0;
    edges(2);
    check("reset pd", 8'h01, {7'h0, pd});
    check("reset alert", 8'h03, {6'h0, alert_n, ~aoe});
    t_rw();
    t_irq();
    t_aux();
    t_clear();
    results();
  end
endmodule
